/* File: otxc_pkg.sv */
// constants for the oscillator trim and external clock control block
package otxc_pkg;
	// special function register addresses
	localparam logic [7:0] HF_TRIM_ADDR   = 8'hB3;
	localparam logic [7:0] LF_CTRL_ADDR   = 8'hB4;
	localparam logic [7:0] XOSC_CTRL_ADDR = 8'hB1;
	// high-frequency trim field
	localparam int         HF_TRIM_W      = 5;
	localparam logic [4:0] HF_TRIM_DEF    = 5'h10;
	// low-frequency control fields
	localparam int         LF_ON_BIT      = 7;
	localparam int         LF_SETTLED_BIT = 6;
	localparam int         LF_TRIM_HI     = 5;
	localparam int         LF_TRIM_LO     = 2;
	localparam logic [7:0] LF_CTRL_RESET  = 8'h00;
	localparam int         LF_SETTLE_EDGES = 4;
	// external oscillator control fields
	localparam int         XOSC_MODE_HI   = 6;
	localparam int         XOSC_MODE_LO   = 4;
	localparam logic [7:0] XOSC_RESET     = 8'h00;
	localparam int         XTAL_VALID_BIT = 7;
	localparam int         XTAL_SETTLE_EDGES = 16;
	// external oscillator modes
	localparam logic [2:0] XM_OFF      = 3'h0;
	localparam logic [2:0] XM_CMOS     = 3'h2;
	localparam logic [2:0] XM_CMOS_DIV = 3'h3;
	localparam logic [2:0] XM_RC       = 3'h4;
	localparam logic [2:0] XM_CAP      = 3'h5;
	localparam logic [2:0] XM_XTAL     = 3'h6;
	localparam logic [2:0] XM_XTAL_DIV = 3'h7;
	// timing
	localparam int         CLK_PERIOD_PS = 5000;
	localparam int         LF_NOMINAL_KHZ = 80;
	localparam int         XDIV = 8;
endpackage

/* File: otxc_top.sv */
// oscillator trim, low-frequency oscillator and external clock control
`timescale 1ns/100ps
`default_nettype none
module otxc_top #(
	parameter logic [4:0] HF_TRIM_FACTORY = otxc_pkg::HF_TRIM_DEF
) (
	// clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	// special function register port
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_write,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic      [7:0]  o_sfr_rdata,
	// analog oscillator cores
	output logic      [4:0]  o_hf_period_trim,
	output logic             o_lf_osc_on,
	output logic      [3:0]  o_lf_fine_trim,
	input  wire logic        i_lf_osc_raw,
	output logic             o_lf_clock_out,
	input  wire logic        i_xosc_clock,
	input  wire logic        i_xosc_amp_ok,
	output logic      [2:0]  o_xosc_mode,
	output logic      [2:0]  o_xosc_range_code,
	// pin ownership
	output logic             o_xosc_in_pin_owned,
	output logic             o_xosc_out_pin_owned,
	// timer capture
	input  wire logic        i_t2_capture_mode,
	input  wire logic        i_t3_capture_mode,
	input  wire logic [15:0] i_t2_count,
	input  wire logic [15:0] i_t3_count,
	output logic             o_t2_capture,
	output logic             o_t3_capture,
	output logic      [15:0] o_t2_reload_pair,
	output logic      [15:0] o_t3_reload_pair,
	// external clock over eight, system clock domain
	output logic             o_xosc_div8_tick
);
	// register map, all on the special function register port
	//   hf trim register
	//     bits 7:5  unused, read zero, writes ignored
	//     bits 4:0  period trim, lower is faster
	//     reset     factory value from the parameter
	//   lf control register
	//     bit 7     oscillator enable, resets low
	//     bit 6     settled flag, read only
	//     bits 5:2  fine trim
	//     bits 1:0  output divider select
	//   external oscillator control register
	//     bit 7     crystal valid flag, read only
	//     bits 6:4  oscillator mode
	//     bit 3     reserved, reads zero
	//     bits 2:0  frequency range code, passed straight to the core
	//
	// port timing
	//   a write lands on the edge where the strobe is high
	//   read data follows the address one cycle later
	//   core controls follow the register one cycle later still
	//   back-to-back writes are fine, there is no busy state
	//
	// oscillator modes
	//   000 off, no pin taken, no divided tick
	//   010 and 011 cmos clock on the output pin
	//   100 rc network on the output pin
	//   101 capacitor on the output pin
	//   110 and 111 crystal or resonator across both pins
	//   001 is left undecoded and behaves as a one-pin mode
	//
	// hazards and limits
	//   raw oscillator levels are asynchronous; each passes two flops (the lf level is first gated by the enable)
	//   before any logic looks at it
	//   edge detection adds two to three cycles of latency, so captured
	//   counts trail the true edge by a fixed amount that cancels when
	//   software takes the difference of two captures
	//   the external source must stay at or below half the system clock
	//   or edges are lost in the synchroniser; slower is safer
	//   the divided tick is a one-cycle pulse, not a square wave, so a
	//   peripheral uses it as a count enable
	//   the settled flag is an edge count, not a frequency measurement;
	//   it only proves the core is toggling
	//   crystal valid needs both the amplitude detector and a run of
	//   clean edges, and drops at once if the amplitude detector goes away; a stop in edges does not clear it
	//   leaving crystal mode clears the valid flag and its counter
	//   disabling the lf core clears the settled flag, the divider and
	//   the edge count, so every enable starts from scratch
	//   the divider keeps counting through a change of select code, so
	//   the first output period after a change may be short
	//   trim writes reach the cores a cycle after the register; the cores must tolerate a
	//   step in trim while running
	//
	// state
	logic [4:0]  hf_trim_q;
	logic [7:0]  lf_ctrl_q;
	logic        lf_settled_q;
	logic [2:0]  lf_settle_cnt_q;
	logic [6:0]  xosc_ctrl_q;
	logic        xtal_valid_q;
	logic [4:0]  xtal_cnt_q;
	logic [2:0]  lf_sync_q;
	logic [2:0]  lf_div_q;
	logic [2:0]  xdiv_cnt_q;
	logic [2:0]  xsync_q;
	logic [2:0]  amp_sync_q;
	logic        lf_rise;
	logic        lf_fall;
	logic        xosc_rise;
	logic        xtal_mode;
	logic        lf_on;
	logic [1:0]  lf_div_sel;

	assign lf_on      = lf_ctrl_q[otxc_pkg::LF_ON_BIT];
	assign lf_div_sel = lf_ctrl_q[1:0];
	assign xtal_mode  = (xosc_ctrl_q[6:4] == otxc_pkg::XM_XTAL) ||
	                    (xosc_ctrl_q[6:4] == otxc_pkg::XM_XTAL_DIV);

	// high-frequency trim, reset loads the factory value
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			hf_trim_q <= HF_TRIM_FACTORY;
		end else if (i_sfr_write && i_sfr_addr == otxc_pkg::HF_TRIM_ADDR) begin
			hf_trim_q <= i_sfr_wdata[4:0];
		end
	end

	// low-frequency control; bit 6 is never stored
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			lf_ctrl_q <= otxc_pkg::LF_CTRL_RESET;
		end else if (i_sfr_write && i_sfr_addr == otxc_pkg::LF_CTRL_ADDR) begin
			lf_ctrl_q <= {i_sfr_wdata[7], 1'b0, i_sfr_wdata[5:0]};
		end
	end

	// external oscillator control, bit 3 reserved
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			xosc_ctrl_q <= otxc_pkg::XOSC_RESET[6:0];
		end else if (i_sfr_write && i_sfr_addr == otxc_pkg::XOSC_CTRL_ADDR) begin
			xosc_ctrl_q <= {i_sfr_wdata[6:4], 1'b0, i_sfr_wdata[2:0]};
		end
	end

	// synchronise the raw oscillator outputs; stage 0 feeds stage 1 only
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			lf_sync_q  <= 3'h0;
			xsync_q    <= 3'h0;
			amp_sync_q <= 3'h0;
		end else begin
			lf_sync_q  <= {lf_sync_q[1:0], i_lf_osc_raw & lf_on};
			xsync_q    <= {xsync_q[1:0], i_xosc_clock};
			amp_sync_q <= {amp_sync_q[1:0], i_xosc_amp_ok};
		end
	end

	assign lf_rise   = lf_sync_q[1] & ~lf_sync_q[2];
	assign lf_fall   = ~lf_sync_q[1] & lf_sync_q[2];
	assign xosc_rise = xsync_q[1] & ~xsync_q[2] &&
	                   xosc_ctrl_q[6:4] != otxc_pkg::XM_OFF;

	// ready flag: count oscillator edges after enable; cleared when off
	always_ff @(posedge i_clock) begin
		if (i_reset || !lf_on) begin
			lf_settle_cnt_q <= 3'h0;
			lf_settled_q    <= 1'b0;
		end else if (lf_rise && !lf_settled_q) begin
			lf_settle_cnt_q <= lf_settle_cnt_q + 3'h1;
			if (lf_settle_cnt_q == 3'(otxc_pkg::LF_SETTLE_EDGES - 1)) begin
				lf_settled_q <= 1'b1;
			end
		end
	end

	// output divider counts rising edges of the 80 kHz source
	always_ff @(posedge i_clock) begin
		if (i_reset || !lf_on) begin
			lf_div_q <= 3'h0;
		end else if (lf_rise) begin
			lf_div_q <= lf_div_q + 3'h1;
		end
	end

	// divide by 8/4/2/1 for codes 00/01/10/11
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_lf_clock_out <= 1'b0;
		end else begin
			case (lf_div_sel)
				2'h0: o_lf_clock_out <= lf_div_q[2];
				2'h1: o_lf_clock_out <= lf_div_q[1];
				2'h2: o_lf_clock_out <= lf_div_q[0];
				default: o_lf_clock_out <= lf_sync_q[2];
			endcase
		end
	end

	// capture timer counts on oscillator edges into the reload pairs
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_t2_reload_pair <= 16'h0000;
			o_t3_reload_pair <= 16'h0000;
			o_t2_capture     <= 1'b0;
			o_t3_capture     <= 1'b0;
		end else begin
			o_t2_capture <= i_t2_capture_mode & lf_fall;
			o_t3_capture <= i_t3_capture_mode & lf_rise;
			if (i_t2_capture_mode && lf_fall) begin
				o_t2_reload_pair <= i_t2_count;
			end
			if (i_t3_capture_mode && lf_rise) begin
				o_t3_reload_pair <= i_t3_count;
			end
		end
	end

	// external clock over eight as a one-cycle tick; sampling adds up to
	// one system cycle of jitter to each tick
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			xdiv_cnt_q       <= 3'h0;
			o_xosc_div8_tick <= 1'b0;
		end else begin
			o_xosc_div8_tick <= 1'b0;
			if (xosc_rise) begin
				xdiv_cnt_q <= xdiv_cnt_q + 3'h1;
				o_xosc_div8_tick <= (xdiv_cnt_q == 3'(otxc_pkg::XDIV - 1));
			end
		end
	end

	// crystal valid after amplitude good and a run of clean edges
	always_ff @(posedge i_clock) begin
		if (i_reset || !xtal_mode || !amp_sync_q[2]) begin
			xtal_cnt_q   <= 5'h00;
			xtal_valid_q <= 1'b0;
		end else if (xosc_rise && !xtal_valid_q) begin
			xtal_cnt_q <= xtal_cnt_q + 5'h01;
			if (xtal_cnt_q == 5'(otxc_pkg::XTAL_SETTLE_EDGES - 1)) begin
				xtal_valid_q <= 1'b1;
			end
		end
	end

	// register read mux; unmapped addresses read zero
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_sfr_rdata <= 8'h00;
		end else begin
			case (i_sfr_addr)
				otxc_pkg::HF_TRIM_ADDR: o_sfr_rdata <= {3'h0, hf_trim_q};
				otxc_pkg::LF_CTRL_ADDR: o_sfr_rdata <= {lf_ctrl_q[7],
					lf_settled_q, lf_ctrl_q[5:0]};
				otxc_pkg::XOSC_CTRL_ADDR: o_sfr_rdata <= {xtal_valid_q,
					xosc_ctrl_q};
				default: o_sfr_rdata <= 8'h00;
			endcase
		end
	end

	// analog controls and pin ownership
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_hf_period_trim     <= HF_TRIM_FACTORY;
			o_lf_osc_on          <= 1'b0;
			o_lf_fine_trim       <= 4'h0;
			o_xosc_mode          <= otxc_pkg::XM_OFF;
			o_xosc_range_code    <= 3'h0;
			o_xosc_in_pin_owned  <= 1'b0;
			o_xosc_out_pin_owned <= 1'b0;
		end else begin
			o_hf_period_trim     <= hf_trim_q;
			o_lf_osc_on          <= lf_on;
			o_lf_fine_trim       <= lf_ctrl_q[5:2];
			o_xosc_mode          <= xosc_ctrl_q[6:4];
			o_xosc_range_code    <= xosc_ctrl_q[2:0];
			o_xosc_in_pin_owned  <= xtal_mode;
			o_xosc_out_pin_owned <= xosc_ctrl_q[6:4] != otxc_pkg::XM_OFF;
		end
	end
endmodule
`default_nettype wire

/* File: otxc_asserts.sv */
// concurrent checks on the oscillator control block ports
`timescale 1ns/100ps
`default_nettype none
module otxc_asserts (
	// clock, reset and register port
	input wire logic        i_clock,
	input wire logic        i_reset,
	input wire logic [7:0]  i_sfr_addr,
	input wire logic        i_sfr_write,
	input wire logic [7:0]  i_sfr_wdata,
	input wire logic [7:0]  o_sfr_rdata,
	// core controls, pins, capture and tick
	input wire logic [4:0]  o_hf_period_trim,
	input wire logic        o_lf_osc_on,
	input wire logic [3:0]  o_lf_fine_trim,
	input wire logic [2:0]  o_xosc_mode,
	input wire logic        o_xosc_in_pin_owned,
	input wire logic        o_xosc_out_pin_owned,
	input wire logic        i_t3_capture_mode,
	input wire logic        o_t2_capture,
	input wire logic        o_t3_capture,
	input wire logic        o_xosc_div8_tick
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_reset);
	// core controls follow a write two edges later
	chk_hf_trim_out: assert property (i_sfr_write && i_sfr_addr == 8'hB3
		|-> ##2 o_hf_period_trim == $past(i_sfr_wdata[4:0], 2))
		else $error("hf trim output wrong");
	chk_lf_enable_out: assert property (i_sfr_write && i_sfr_addr == 8'hB4
		|-> ##2 o_lf_osc_on == $past(i_sfr_wdata[7], 2))
		else $error("lf enable output wrong");
	chk_lf_trim_out: assert property (i_sfr_write && i_sfr_addr == 8'hB4
		|-> ##2 o_lf_fine_trim == $past(i_sfr_wdata[5:2], 2))
		else $error("lf trim output wrong");
	// ready must read low while the core has been off for a while
	chk_ready_off: assert property ((!o_lf_osc_on) [*3]
		##0 ($past(i_sfr_addr) == 8'hB4) |-> !o_sfr_rdata[6])
		else $error("ready flag high while disabled");
	// no t3 capture without capture mode; t2 captures are single pulses
	chk_t3_no_mode: assert property ((!i_t3_capture_mode) [*4] |=> !o_t3_capture)
		else $error("capture without capture mode");
	chk_t2_single: assert property (o_t2_capture |=> !o_t2_capture)
		else $error("capture pulse too long");
	// pin ownership follows the oscillator mode
	chk_in_pin_mode: assert property (o_xosc_in_pin_owned |-> o_xosc_mode[2:1] == 2'b11)
		else $error("input pin taken outside crystal mode");
	chk_out_pin_mode: assert property (o_xosc_out_pin_owned == (o_xosc_mode != 3'h0))
		else $error("output pin ownership wrong");
	// eight external edges can never take fewer than eight cycles
	chk_tick_spacing: assert property (o_xosc_div8_tick |=> (!o_xosc_div8_tick) [*7])
		else $error("divided tick too close");
	chk_tick_off: assert property ((o_xosc_mode == 3'h0) [*3] |=> !o_xosc_div8_tick)
		else $error("tick while oscillator off");
endmodule
bind otxc_top otxc_asserts chk (.i_clock, .i_reset, .i_sfr_addr, .i_sfr_write,
	.i_sfr_wdata, .o_sfr_rdata, .o_hf_period_trim, .o_lf_osc_on, .o_lf_fine_trim,
	.o_xosc_mode, .o_xosc_in_pin_owned, .o_xosc_out_pin_owned, .i_t3_capture_mode,
	.o_t2_capture, .o_t3_capture, .o_xosc_div8_tick);
`default_nettype wire

/* File: otxc_osc_model.sv */
// behavioural oscillator sources on the far side of the block
`timescale 1ns/100ps
`default_nettype none
module otxc_osc_model (
	// system clock and controls from the block
	input  wire logic       i_clock,
	input  wire logic       i_reset,
	input  wire logic       i_lf_osc_on,
	input  wire logic [2:0] i_xosc_mode,
	// oscillator levels
	output logic            o_lf_osc_raw,
	output logic            o_xosc_clock,
	output logic            o_xosc_amp_ok
);
	logic [5:0] lf_cnt_q;
	logic [7:0] amp_cnt_q;
	logic [1:0] x_cnt_q;
	// lf core: period of 40 cycles, stands still while disabled
	always_ff @(posedge i_clock) begin
		lf_cnt_q <= (i_reset || lf_cnt_q == 6'h13) ? 6'h00 : lf_cnt_q + 6'h01;
		if (i_reset)
			o_lf_osc_raw <= 1'b0;
		else if (i_lf_osc_on && lf_cnt_q == 6'h13)
			o_lf_osc_raw <= !o_lf_osc_raw;
	end
	// external source at a quarter of the system clock, still when off
	always_ff @(posedge i_clock) begin
		x_cnt_q <= (i_reset || i_xosc_mode == 3'h0) ? 2'h0 : x_cnt_q + 2'h1;
		o_xosc_clock <= x_cnt_q[1];
		amp_cnt_q <= (i_xosc_mode[2:1] != 2'b11) ? 8'h00 : amp_cnt_q + {7'h00, !amp_cnt_q[6]};
		o_xosc_amp_ok <= amp_cnt_q[6];
	end
endmodule
`default_nettype wire

/* File: otxc_top_tb_top.sv */
// self-checking bench for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module otxc_top_tb_top;
	logic        i_clock, i_reset, i_sfr_write, i_lf_osc_raw, i_xosc_clock;
	logic        i_xosc_amp_ok, i_t2_capture_mode, i_t3_capture_mode, o_lf_osc_on;
	logic        o_lf_clock_out, o_xosc_in_pin_owned, o_xosc_out_pin_owned;
	logic        o_t2_capture, o_t3_capture, o_xosc_div8_tick;
	logic [7:0]  i_sfr_addr, i_sfr_wdata, o_sfr_rdata, v;
	logic [4:0]  o_hf_period_trim;
	logic [3:0]  o_lf_fine_trim;
	logic [2:0]  o_xosc_mode, o_xosc_range_code;
	logic [15:0] i_t2_count, i_t3_count, o_t2_reload_pair, o_t3_reload_pair, r[2];
	int          mismatches, n_checks, k, t;
	localparam logic [2:0] MODES [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
	otxc_top dut (.i_clock, .i_reset, .i_sfr_addr, .i_sfr_write, .i_sfr_wdata,
		.o_sfr_rdata, .o_hf_period_trim, .o_lf_osc_on, .o_lf_fine_trim, .i_lf_osc_raw,
		.o_lf_clock_out, .i_xosc_clock, .i_xosc_amp_ok, .o_xosc_mode, .o_xosc_range_code,
		.o_xosc_in_pin_owned, .o_xosc_out_pin_owned, .i_t2_capture_mode,
		.i_t3_capture_mode, .i_t2_count, .i_t3_count, .o_t2_capture, .o_t3_capture,
		.o_t2_reload_pair, .o_t3_reload_pair, .o_xosc_div8_tick);
	otxc_osc_model model (.i_clock, .i_reset, .i_lf_osc_on(o_lf_osc_on),
		.i_xosc_mode(o_xosc_mode), .o_lf_osc_raw(i_lf_osc_raw),
		.o_xosc_clock(i_xosc_clock), .o_xosc_amp_ok(i_xosc_amp_ok));
	// clock and free-running timer counts
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = !i_clock;
	end
	always @(posedge i_clock) begin
		i_t2_count <= i_t2_count + 16'h0001;
		i_t3_count <= i_t3_count + 16'h0001;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_sfr_addr <= a;
		i_sfr_wdata <= d;
		i_sfr_write <= 1'b1;
		@(posedge i_clock);
		i_sfr_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		i_sfr_addr <= a;
		repeat (2) @(posedge i_clock);
		#1 d = o_sfr_rdata;
	endtask
	// bounded wait for a rising level, t counts the cycles spent
	task automatic wait_rise(ref logic s, output int n);
		n = 0;
		while (s !== 1'b0 && n < 3000) begin @(posedge i_clock); #1 n++; end
		while (s !== 1'b1 && n < 3000) begin @(posedge i_clock); #1 n++; end
	endtask
	task automatic final_report();
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// watchdog: the sequence needs well under ten thousand cycles
	initial begin
		#250us;
		mismatches++;
		final_report();
	end
	initial begin
		{i_reset, i_sfr_write, i_sfr_addr, i_sfr_wdata} = {2'b10, 16'h0000};
		{i_t2_capture_mode, i_t3_capture_mode, i_t2_count} = 18'h00000;
		{i_t3_count, mismatches, n_checks} = {16'h1000, 64'h0};
		repeat (10) @(posedge i_clock);
		i_reset <= 1'b0;
		rd(8'hB3, v); `CHK("hf reset", {3'h0, otxc_pkg::HF_TRIM_DEF}, v)
		rd(8'hB4, v); `CHK("lf reset", otxc_pkg::LF_CTRL_RESET, v)
		wr(8'hB3, 8'hFF);
		wr(8'hB5, 8'h00);
		rd(8'hB3, v); `CHK("hf trim", 8'h1F, v)
		`CHK("hf core", 5'h1F, o_hf_period_trim)
		wr(8'hB4, 8'hFF);
		rd(8'hB4, v); `CHK("lf early", 8'hBF, v)
		`CHK("lf trim", 4'hF, o_lf_fine_trim)
		for (k = 0; k < 100 && v[6] !== 1'b1; k++) rd(8'hB4, v);
		`CHK("lf ready", 8'hFF, v)
		// each divider code: period of the output against the raw 40 cycles
		for (k = 0; k < 4; k++) begin
			wr(8'hB4, {6'h20, k[1:0]});
			repeat (3) wait_rise(o_lf_clock_out, t);
			`CHK("lf period", 40 * (8 >> k), t)
		end
		i_t2_capture_mode <= 1'b1;
		i_t3_capture_mode <= 1'b1;
		for (k = 0; k < 2; k++) begin
			wait_rise(o_t2_capture, t);
			@(posedge i_clock); #1 r[k] = o_t2_reload_pair;
			`CHK("t2 edge", 1'b0, i_lf_osc_raw)
			`CHK("t2 fresh", 1'b1, i_t2_count - r[k] < 16'h0008)
		end
		`CHK("t2 period", 16'h0028, r[1] - r[0])
		for (k = 0; k < 2; k++) begin
			wait_rise(o_t3_capture, t);
			@(posedge i_clock); #1 r[k] = o_t3_reload_pair;
			`CHK("t3 edge", 1'b1, i_lf_osc_raw)
		end
		`CHK("t3 period", 16'h0028, r[1] - r[0])
		wr(8'hB4, 8'h00);
		rd(8'hB4, v); `CHK("lf off", 8'h00, v)
		`CHK("lf core off", 1'b0, o_lf_osc_on)
		wr(8'hB4, 8'h80);
		rd(8'hB4, v); `CHK("lf again", 8'h80, v)
		// every mode but 001 with its own range code; bit 3 not writable, bit 7 written but not checked
		for (k = 0; k < 7; k++) begin
			wr(8'hB1, {1'b1, MODES[k], 1'b1, k[2:0]});
			rd(8'hB1, v); `CHK("xosc reg", {MODES[k], 1'b0, k[2:0]}, v[6:0])
			`CHK("xosc mode", MODES[k], o_xosc_mode)
			`CHK("xosc range", k[2:0], o_xosc_range_code)
			`CHK("in pin", MODES[k][2:1] == 2'b11, o_xosc_in_pin_owned)
			`CHK("out pin", MODES[k] != 3'h0, o_xosc_out_pin_owned)
		end
		wr(8'hB1, 8'h67);
		repeat (200) @(posedge i_clock);
		for (k = 0; k < 100 && v[7] !== 1'b1; k++) rd(8'hB1, v);
		`CHK("xtal valid", 1'b1, v[7])
		repeat (2) wait_rise(o_xosc_div8_tick, t);
		`CHK("div8 gap", 32, t)
		wr(8'hB1, 8'h00);
		rd(8'hB1, v); `CHK("xosc off", 8'h00, v)
		final_report();
	end
endmodule
`default_nettype wire
